// file: sim/crol_ctrl_bench.sv
`timescale 1ns/1ps
// self-checking bench; short timer via a slow nominal clock setting
module crol_ctrl_bench;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, lim1, lim2, probe, flt_n, flt, seen;
    logic        cmp1 = 1'b0, cmp2 = 1'b0, open_s = 1'b0, active = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  lvl, t;
    logic [33:0] exp_q[$], e_now;
    int          err_total = 0, n_checks = 0, seed = 46, n, t0;
    initial forever #20 clk = ~clk;
    crol_ctrl #(.CLK_MHZ(1)) u_dut
    (
        .i_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_trip_cmp_one(cmp1), .i_trip_cmp_two(cmp2), .i_open_sense(open_s),
        .i_bridge_active(active), .o_trip_level_sel(lvl), .o_limit_one(lim1),
        .o_limit_two(lim2), .o_ol_probe(probe), .o_fault_out_n(flt_n), .o_fault_flag(flt)
    );
    crol_host u_host
    (
        .i_clk(clk), .i_pready(pready), .i_prdata(prdata), .o_psel(psel),
        .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata)
    );
    task chk(input string nm, input logic [32:0] s, input logic [32:0] e);
        n_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("Error %s exp %h saw %h", nm, e, s);
        end
    endtask
    // note the expectation first, the watcher pops it at pready
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
        exp_q.push_back(e);
        u_host.xfer(w, a, d, rd);
    endtask
    task watch(input int c);
        seen = 1'b0;
        repeat (c) @(posedge clk) seen |= probe;
    endtask
    task finish_test;
        err_total += u_host.tmo;
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // answer watcher; top bit of a note marks it as compared
    always @(posedge clk)
        if (pready === 1'b1 && exp_q.size() > 0)
        begin
            e_now = exp_q.pop_front();
            if (e_now[33])
                chk("apb", {pslverr, prdata}, e_now[32:0]);
        end
    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        acc(0, 12'h014, 0, {2'b10, 32'h08});
        acc(0, 12'h01c, 0, {2'b10, 32'h0});
        acc(0, 12'h020, 0, {2'b11, 32'h0});
        {cmp1, cmp2} <= 2'b11;
        for (int k = 3; k >= 0; k--)
        begin
            t = 2'($random(seed));
            acc(1, 12'h014, {t, k[1:0]}, 0);
            acc(0, 12'h014, 0, {2'b10, 28'h0, t, k[1:0]});
            repeat (6) @(posedge clk);
            chk("limit", {lim1, lim2}, {~k[0], ~k[1]});
            chk("level", lvl, t);
        end
        chk("fault", {flt_n, flt}, 2'b10);
        acc(1, 12'h01c, 1, 0);
        repeat (3) @(posedge clk);
        chk("fault", {flt_n, flt}, 2'b01);
        {cmp1, cmp2, open_s} <= 3'b001;
        repeat (4) @(posedge clk);
        acc(1, 12'h018, 4, 0);
        repeat (3) @(posedge clk);
        chk("fault", {flt_n, flt}, 2'b10);
        for (int s = 0; s < 2; s++)
        begin
            acc(1, 12'h014, 32'h40 | (s << 5), 0);
            t0 = $time / 40;
            acc(0, 12'h018, 0, {2'b10, 32'h1});
            n = 0;
            do
            begin
                acc(0, 12'h014, 0, 0);
                n++;
            end
            while (rd[6] !== 1'b0 && n < 2000);
            n = $time / 40 - t0;
            chk("delay", n >= (s ? 1200 : 300) && n < (s ? 1260 : 360), 1);
            acc(0, 12'h018, 0, {2'b10, 32'h2});
        end
        active <= 1'b1;
        watch(600);
        chk("probe", seen, 0);
        acc(1, 12'h014, 32'h10, 0);
        watch(600);
        chk("probe", seen, 1);
        finish_test();
    end
endmodule

// file: sim/crol_host.sv
`timescale 1ns/1ps
// host model: apb master, one transfer at a time
module crol_host
(
    // clock and answer
    input  wire logic        i_clk,
    input  wire logic        i_pready,
    input  wire logic [31:0] i_prdata,
    // request
    output logic             o_psel = 1'b0,
    output logic             o_penable = 1'b0,
    output logic             o_pwrite = 1'b0,
    output logic [11:0]      o_paddr = 12'h0,
    output logic [31:0]      o_pwdata = 32'h0
);
    int tmo = 0;
    // released address and data lines show the inverse, so stale values never pass
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge i_clk);
        {o_psel, o_pwrite, o_paddr, o_pwdata} <= {1'b1, w, a, d};
        @(posedge i_clk);
        o_penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (i_pready !== 1'b1 && n < 50);
        if (n >= 50)
            tmo++;
        q = i_prdata;
        {o_psel, o_penable, o_paddr, o_pwdata} <= {2'b00, ~a, ~d};
    endtask
endmodule

// file: sim/crol_monitor.sv
`timescale 1ns/1ps
// port-level checks beside the register block
module crol_monitor
(
    // clock, reset and bus
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // control outputs
    input wire logic [1:0]  o_trip_level_sel,
    input wire logic        o_limit_one,
    input wire logic        o_fault_flag,
    input wire logic        o_fault_out_n
);
    logic       dis_seen;
    logic       rep_seen;
    wire        wr_done = i_psel & i_penable & o_pready & i_pwrite;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // shadow of written bits, so gating is judged from the ports alone
    always_ff @(posedge i_clk)
        if (!i_rst_b)
            {dis_seen, rep_seen} <= 2'h0;
        else if (wr_done && i_paddr == 12'h014)
            dis_seen <= i_pwdata[0];
        else if (wr_done && i_paddr == 12'h01c)
            rep_seen <= i_pwdata[0];
    rst_vals_a: assert property (
        $rose(i_rst_b) |-> o_fault_out_n && !o_fault_flag && o_trip_level_sel == 2'b10)
        else $error("reset values wrong");
    pready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    setup_answer_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no answer after setup");
    map_err_a: assert property (
        o_pready |-> o_pslverr == !(i_paddr inside {12'h014, 12'h018, 12'h01c}))
        else $error("slave error does not match address map");
    trip_write_a: assert property (
        wr_done && i_paddr == 12'h014 |-> ##2 o_trip_level_sel == $past(i_pwdata[3:2], 2))
        else $error("trip level not updated by write");
    limit_gate_a: assert property (
        dis_seen && $past(dis_seen) |-> !o_limit_one)
        else $error("limit on a disabled output");
    report_gate_a: assert property (
        !rep_seen && !$past(rep_seen) |-> !o_fault_flag)
        else $error("trip reported while reporting off");
    fault_pair_a: assert property (o_fault_out_n == !o_fault_flag)
        else $error("fault pin and flag disagree");
endmodule

bind crol_ctrl crol_monitor u_mon
(
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_trip_level_sel(o_trip_level_sel),
    .o_limit_one(o_limit_one), .o_fault_flag(o_fault_flag), .o_fault_out_n(o_fault_out_n)
);

// file: src/crol_ctrl.sv
`timescale 1ns/1ps
`include "crol_regs.svh"

// Summary of operation
// RL1: writing one to standby run starts the open-load test; bit clears when done.
// RL2: open-load delay is 300 us when delay select is 0, 1.2 ms when 1.
// RL3: active-mode open-load check runs only while its enable bit is one.
// RL4: disable field 00 regulates both, 01 frees output one, 10 two, 11 both.
// RL5: while regulation is enabled, current is limited by the trip comparator.
// RL6: trip level field selects 4, 5.4, 6.5 or 7 A; resets to 6.5 A.
// RL7: trip events reach fault output and fault flag only when reporting enabled.
module crol_ctrl
    import crol_pkg::*;
#(
    parameter int CLK_MHZ = 25,
    parameter int CW      = 16
)
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // analog-side pins
    input  wire logic        i_trip_cmp_one,
    input  wire logic        i_trip_cmp_two,
    input  wire logic        i_open_sense,
    input  wire logic        i_bridge_active,
    // control outputs
    output logic [1:0]       o_trip_level_sel,
    output logic             o_limit_one,
    output logic             o_limit_two,
    output logic             o_ol_probe,
    output logic             o_fault_out_n,
    output logic             o_fault_flag
);
    // configuration
    logic [7:0]     ctrl;
    logic           trip_report_enable;
    // status
    logic           ol_busy;
    logic           open_found;
    logic           trip_seen;
    crol_ol_state_t ol_state;
    crol_ol_state_t next_ol_state;
    // synchronisers, first stage read only by second
    logic [3:0]     sync_a;
    logic [3:0]     sync_b;
    logic           timer_start;
    logic           timer_done;

    // field views
    wire       open_load_standby_run   = ctrl[`CROL_BIT_OL_RUN];
    wire       open_load_delay_sel     = ctrl[`CROL_BIT_OL_DLY];
    wire       open_load_active_enable = ctrl[`CROL_BIT_OL_ACT];
    wire [1:0] trip_level_sel          = ctrl[`CROL_TRIP_HI:`CROL_TRIP_LO];
    wire [1:0] regulation_disable      = ctrl[`CROL_DIS_HI:`CROL_DIS_LO];
    wire       trip_one    = sync_b[0];
    wire       trip_two    = sync_b[1];
    wire       open_sense  = sync_b[2];
    wire       bridge_on   = sync_b[3];

    // apb decode; access phase completes in one cycle
    wire       acc         = i_psel && i_penable;
    wire       wr          = acc && i_pwrite;
    wire       hit_ctrl    = (i_paddr == `CROL_ADDR_CTRL);
    wire       hit_stat    = (i_paddr == `CROL_ADDR_STATUS);
    wire       hit_rep     = (i_paddr == `CROL_ADDR_REPORT);
    wire       mapped      = hit_ctrl || hit_stat || hit_rep;
    wire       wr_ctrl     = wr && hit_ctrl && i_pstrb[0];
    wire       wr_rep      = wr && hit_rep && i_pstrb[0];
    wire       wr_run      = wr_ctrl && i_pwdata[`CROL_BIT_OL_RUN];

    // regulation per output, gated by disable field
    wire       reg_en_one  = !regulation_disable[0];        // see RL4
    wire       reg_en_two  = !regulation_disable[1];        // see RL4
    wire       trip_event  = (trip_one && reg_en_one) || (trip_two && reg_en_two); // see RL5

    // open-load sequencing: standby test or active check
    wire       act_check   = open_load_active_enable && bridge_on;  // see RL3
    wire       stby_req    = open_load_standby_run && !bridge_on;   // see RL1
    wire       test_end    = (ol_state == CROL_CHECK);

    wire [31:0] rd_mux =
        hit_ctrl ? {24'h000000, ctrl} :
        hit_stat ? {29'h00000000, trip_seen, open_found, ol_busy} :
        hit_rep  ? {31'h00000000, trip_report_enable} : 32'h00000000;

    // open-load state machine
    always_comb
    begin
        next_ol_state = ol_state;
        timer_start   = 1'b0;
        case (ol_state)
            CROL_IDLE:
            begin
                if (stby_req || act_check)
                begin
                    next_ol_state = CROL_WAIT;
                    timer_start   = 1'b1;
                end
            end
            CROL_WAIT:
            begin
                if (timer_done)
                    next_ol_state = CROL_CHECK;
            end
            CROL_CHECK:
                next_ol_state = CROL_IDLE;
            default:
                next_ol_state = CROL_IDLE;
        endcase
    end

    crol_ol_timer
    #(
        .CLK_MHZ (CLK_MHZ),
        .CW      (CW)
    )
    u_timer
    (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_start (timer_start),
        .i_long  (open_load_delay_sel),  // see RL2
        .o_done  (timer_done)
    );

    // pin synchronisers
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end
        else
        begin
            sync_a <= {i_bridge_active, i_open_sense, i_trip_cmp_two, i_trip_cmp_one};
            sync_b <= sync_a;
        end
    end

    // control register; completion clear loses to a fresh host start
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            ctrl               <= `CROL_CTRL_RESET;   // see RL6
            trip_report_enable <= `CROL_REPORT_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= i_pwdata[7:0];
            else if (test_end && !act_check)
                ctrl[`CROL_BIT_OL_RUN] <= 1'b0;        // see RL1
            if (wr_rep)
                trip_report_enable <= i_pwdata[`CROL_BIT_TRIP_REP];
        end
    end

    // state, status and sticky flags; set wins over clear
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            ol_state   <= CROL_IDLE;
            ol_busy    <= 1'b0;
            open_found <= 1'b0;
            trip_seen  <= 1'b0;
        end
        else
        begin
            ol_state   <= next_ol_state;
            ol_busy    <= (next_ol_state != CROL_IDLE);
            if (test_end)
                open_found <= open_sense;
            else if (wr_run)
                open_found <= 1'b0;
            if (trip_event)
                trip_seen <= 1'b1;
            else if (wr && hit_stat && i_pwdata[`CROL_ST_TRIP])
                trip_seen <= 1'b0;
        end
    end

    // registered outputs
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            o_prdata         <= 32'h00000000;
            o_pready         <= 1'b0;
            o_pslverr        <= 1'b0;
            o_trip_level_sel <= CROL_TRIP_6A5;
            o_limit_one      <= 1'b0;
            o_limit_two      <= 1'b0;
            o_ol_probe       <= 1'b0;
            o_fault_out_n    <= 1'b1;
            o_fault_flag     <= 1'b0;
        end
        else
        begin
            o_pready         <= i_psel && !o_pready && !i_penable ? 1'b1 : 1'b0;
            o_prdata         <= rd_mux;
            o_pslverr        <= i_psel && !i_penable && !mapped;
            o_trip_level_sel <= trip_level_sel;                 // see RL6
            o_limit_one      <= trip_one && reg_en_one;         // see RL5
            o_limit_two      <= trip_two && reg_en_two;         // see RL5
            o_ol_probe       <= (next_ol_state != CROL_IDLE);
            o_fault_out_n    <= !(trip_seen && trip_report_enable);  // see RL7
            o_fault_flag     <= trip_seen && trip_report_enable;     // see RL7
        end
    end
endmodule

// file: src/crol_ol_timer.sv
`timescale 1ns/1ps
`include "crol_regs.svh"

// open-load settle delay counter; start loads, done pulses once at expiry
module crol_ol_timer
#(
    parameter int CLK_MHZ     = 25,
    parameter int SHORT_CYC   = `CROL_DLY_SHORT_US * CLK_MHZ,
    parameter int LONG_CYC    = `CROL_DLY_LONG_US * CLK_MHZ,
    parameter int CW          = 16
)
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    // control
    input  wire logic i_start,
    input  wire logic i_long,
    // result
    output logic      o_done
);
    logic [CW-1:0] count;
    logic          running;
    wire  [CW-1:0] load_val = i_long ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1); // see RL2
    wire           expire   = running && (count == '0);

    // down counter, restart wins over expiry
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            count   <= '0;
            running <= 1'b0;
            o_done  <= 1'b0;
        end
        else
        begin
            o_done  <= expire && !i_start;
            running <= i_start || (running && !expire);
            count   <= i_start ? load_val : (running ? count - 1'b1 : count);
        end
    end
endmodule

// file: src/crol_pkg.sv
package crol_pkg;
    typedef enum logic [1:0] {
        CROL_IDLE  = 2'b00,
        CROL_WAIT  = 2'b01,
        CROL_CHECK = 2'b10
    } crol_ol_state_t;

    typedef enum logic [1:0] {
        CROL_TRIP_4A0 = 2'b00,
        CROL_TRIP_5A4 = 2'b01,
        CROL_TRIP_6A5 = 2'b10,
        CROL_TRIP_7A0 = 2'b11
    } crol_trip_t;
endpackage

// file: src/crol_regs.svh
`ifndef CROL_REGS_SVH
`define CROL_REGS_SVH

// register byte addresses (word aligned)
`define CROL_ADDR_CTRL        12'h014
`define CROL_ADDR_STATUS      12'h018
`define CROL_ADDR_REPORT      12'h01c

// control register fields
`define CROL_BIT_RESERVED_BIT         7
`define CROL_BIT_OL_RUN       6
`define CROL_BIT_OL_DLY       5
`define CROL_BIT_OL_ACT       4
`define CROL_TRIP_HI          3
`define CROL_TRIP_LO          2
`define CROL_DIS_HI           1
`define CROL_DIS_LO           0
`define CROL_CTRL_RESET       8'h08

// report register fields
`define CROL_BIT_TRIP_REP     0
`define CROL_REPORT_RESET     1'b0

// status register fields
`define CROL_ST_BUSY          0
`define CROL_ST_OPEN          1
`define CROL_ST_TRIP          2

// open-load delays in microseconds
`define CROL_DLY_SHORT_US     300
`define CROL_DLY_LONG_US      1200

`endif
